// ==== rtl/module_mgmt_control.v ====
// Management control of the module: reset, init, address, interrupt
`include "mgmt_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module module_mgmt_control #(
  parameter [25:0] INIT_CYCLES  = `INIT_CYC,
  parameter [6:0]  PULSE_CYCLES = `INT_PULSE_CYC,
  parameter [3:0]  ADDR_HI      = `ADDR_BASE_HI
) (
  // Clock and reset
  input  wire       ref_clk_in,
  input  wire       nrst_in,
  // Module pins from the host
  input  wire       module_reset_n_in,
  input  wire [2:0] addr_sel_in,
  input  wire       scl_in,
  input  wire       sda_in,
  // Events from module logic
  input  wire       irq_event_in,
  // Pins to the host
  output reg        sda_out,
  output reg        sda_oe_out,
  output reg        interrupt_out_n,
  // Module status
  output reg        data_out_disable_out,
  output reg        mgmt_ready_out
);
  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  reg       rst_m;
  reg       rst_s;
  reg [2:0] addr_m;
  reg [2:0] addr_s;
  reg       scl_m;
  reg       scl_s;
  reg       sda_m;
  reg       sda_s;

  always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      rst_m  <= 1'b0;
      rst_s  <= 1'b0;
      addr_m <= 3'h0;
      addr_s <= 3'h0;
      scl_m  <= 1'b1;
      scl_s  <= 1'b1;
      sda_m  <= 1'b1;
      sda_s  <= 1'b1;
    end else begin
      rst_m  <= module_reset_n_in;
      rst_s  <= rst_m;
      addr_m <= addr_sel_in;
      addr_s <= addr_m;
      scl_m  <= scl_in;
      scl_s  <= scl_m;
      sda_m  <= sda_in;
      sda_s  <= sda_m;
    end
  end

  // Pin reset acts a few cycles after it falls, far inside the limit
  wire core_rst_n = nrst_in & rst_s;

  // --------------------------------------------------------------------
  // Initialisation timer
  // --------------------------------------------------------------------
  reg [25:0] init_cnt;
  reg        ready;

  always @(posedge ref_clk_in) begin
    if (!core_rst_n) begin
      init_cnt <= 26'h0000000;
      ready    <= 1'b0;
    end else if (!ready) begin
      // Full count uses the whole 2000 ms limit; shorten only for simulation
      if (init_cnt >= INIT_CYCLES - 26'h0000001) begin
        ready <= 1'b1;
      end else begin
        init_cnt <= init_cnt + 26'h0000001;
      end
    end
  end

  // --------------------------------------------------------------------
  // Two-wire port
  // --------------------------------------------------------------------
  wire       port_rst_n = core_rst_n & ready;
  wire [6:0] dev_addr   = {ADDR_HI, addr_s};
  wire       port_oe;
  wire       read_done;
  wire       wr_strobe;
  wire [7:0] wr_byte;
  reg        pending;
  reg        static_mode;
  reg [7:0]  flag_byte;

  always @* begin
    flag_byte                   = 8'h00;
    flag_byte[`FLAG_PENDING_BIT] = pending;
    flag_byte[`FLAG_STATIC_BIT]  = static_mode;
  end

  two_wire_slave u_port (
    .clk_in        (ref_clk_in),
    .rst_n_in      (port_rst_n),
    .scl_in        (scl_s),
    .sda_in        (sda_s),
    .dev_addr_in   (dev_addr),
    .read_byte_in  (flag_byte),
    .sda_oe_out    (port_oe),
    .read_done_out (read_done),
    .wr_strobe_out (wr_strobe),
    .wr_byte_out   (wr_byte)
  );

  // --------------------------------------------------------------------
  // Interrupt
  // --------------------------------------------------------------------
  reg [6:0] pulse_cnt;
  reg       pulse_on;
  wire      event_ok = irq_event_in & ready;

  always @(posedge ref_clk_in) begin
    if (!core_rst_n) begin
      static_mode <= 1'b0;
      pending     <= 1'b0;
      pulse_cnt   <= 7'h00;
      pulse_on    <= 1'b0;
    end else begin
      if (wr_strobe) begin
        static_mode <= wr_byte[`CTRL_STATIC_BIT];
      end
      // A new event outranks a clearing read in the same cycle
      if (event_ok) begin
        pending <= 1'b1;
      end else if (read_done) begin
        pending <= 1'b0;
      end
      if (event_ok && !static_mode && !pulse_on) begin
        pulse_on  <= 1'b1;
        pulse_cnt <= 7'h00;
      end else if (pulse_on) begin
        if (pulse_cnt >= PULSE_CYCLES - 7'h01) begin
          pulse_on <= 1'b0;
        end else begin
          pulse_cnt <= pulse_cnt + 7'h01;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (!core_rst_n) begin
      interrupt_out_n      <= 1'b1;
      sda_out              <= 1'b0;
      sda_oe_out           <= 1'b0;
      data_out_disable_out <= 1'b1;
      mgmt_ready_out       <= 1'b0;
    end else begin
      // Static level follows the flag or the event; pulse mode uses the timer or the event
      if (static_mode) begin
        interrupt_out_n <= ~(pending | event_ok);
      end else begin
        interrupt_out_n <= ~(pulse_on | (event_ok & ~pulse_on));
      end
      sda_out              <= 1'b0;
      sda_oe_out           <= port_oe & port_rst_n;
      data_out_disable_out <= ~ready;
      mgmt_ready_out       <= ready;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/mgmt_consts.vh ====
// Constants for the management control block of the pluggable module
// Behaviour
// - Adopt new address-select value within 100 ms
// - Assert interrupt low within 200 ms of event
// - Pulse or static mode; pulses last 5 us; the pin stays low PULSE_CYCLES plus one cycle
// - Interrupt mode defaults to pulse after reset
// - Static: release within 500 us of read
// - Module reset restores defaults, disables data outputs
// - Ignore and never acknowledge bus during reset
// - Resume normal operation within 2000 ms of release; ready comes after the full INIT_CYCLES count plus a few cycles
// - Management port available within 2000 ms of init; the port opens after the full INIT_CYCLES count plus synchroniser cycles
`ifndef MGMT_CONSTS_VH
`define MGMT_CONSTS_VH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define CLK_KHZ          20000
`define ADDR_ASSERT_MS   100
`define INT_ASSERT_MS    200
`define INT_PULSE_US     5
`define INT_DEASSERT_US  500
`define RST_ASSERT_US    100
`define RST_DEASSERT_MS  2000
`define INIT_MS          2000
// Counts at CLK_KHZ, sized to their timers: 5 us and 2000 ms exactly
`define INT_PULSE_CYC    7'h64
`define INIT_CYC         26'h2625a00

// ----------------------------------------------------------------------
// Bus address and byte fields
// ----------------------------------------------------------------------
`define ADDR_BASE_HI     4'ha
`define FLAG_PENDING_BIT 0
`define FLAG_STATIC_BIT  1
`define CTRL_STATIC_BIT  0

`endif

// ==== rtl/two_wire_slave.v ====
// Two-wire management port slave: address match, read and write of one or more bytes
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave (
  // Clock and reset
  input  wire       clk_in,
  input  wire       rst_n_in,
  // Synchronised bus levels
  input  wire       scl_in,
  input  wire       sda_in,
  // Addressing and data
  input  wire [6:0] dev_addr_in,
  input  wire [7:0] read_byte_in,
  // Results
  output reg        sda_oe_out,
  output reg        read_done_out,
  output reg        wr_strobe_out,
  output reg  [7:0] wr_byte_out
);
  localparam S_IDLE  = 5'h01;
  localparam S_RX    = 5'h02;
  localparam S_ACK   = 5'h04;
  localparam S_TX    = 5'h08;
  localparam S_TXACK = 5'h10;

  reg       scl_d;
  reg       sda_d;
  reg [4:0] state;
  reg [3:0] cnt;
  reg [7:0] sh;
  reg       first;
  reg       rw;
  reg       read_seen;
  reg       ack_n;

  wire scl_rise = scl_in & ~scl_d;
  wire scl_fall = ~scl_in & scl_d;
  wire start    = scl_in & scl_d & sda_d & ~sda_in;
  wire stop     = scl_in & scl_d & ~sda_d & sda_in;

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      scl_d         <= 1'b1;
      sda_d         <= 1'b1;
      state         <= S_IDLE;
      cnt           <= 4'h0;
      sh            <= 8'h00;
      first         <= 1'b0;
      rw            <= 1'b0;
      read_seen     <= 1'b0;
      ack_n         <= 1'b1;
      sda_oe_out    <= 1'b0;
      read_done_out <= 1'b0;
      wr_strobe_out <= 1'b0;
      wr_byte_out   <= 8'h00;
    end else begin
      scl_d         <= scl_in;
      sda_d         <= sda_in;
      read_done_out <= 1'b0;
      wr_strobe_out <= 1'b0;
      if (start) begin
        state      <= S_RX;
        cnt        <= 4'h0;
        first      <= 1'b1;
        sda_oe_out <= 1'b0;
      end else if (stop) begin
        // Clear-on-read takes effect only once the whole read has ended
        read_done_out <= read_seen;
        read_seen     <= 1'b0;
        state         <= S_IDLE;
        sda_oe_out    <= 1'b0;
      end else begin
        case (state)
          S_RX: begin
            if (scl_rise) begin
              sh  <= {sh[6:0], sda_in};
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt == 4'h8) begin
              if (first) begin
                if (sh[7:1] == dev_addr_in) begin
                  rw         <= sh[0];
                  read_seen  <= sh[0];
                  sda_oe_out <= 1'b1;
                  state      <= S_ACK;
                end else begin
                  state <= S_IDLE;
                end
              end else begin
                wr_strobe_out <= 1'b1;
                wr_byte_out   <= sh;
                sda_oe_out    <= 1'b1;
                state         <= S_ACK;
              end
              first <= 1'b0;
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              cnt <= 4'h0;
              if (rw) begin
                sh         <= read_byte_in;
                sda_oe_out <= ~read_byte_in[7];
                state      <= S_TX;
              end else begin
                sda_oe_out <= 1'b0;
                state      <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_rise) begin
              cnt <= cnt + 4'h1;
            end else if (scl_fall) begin
              if (cnt == 4'h8) begin
                sda_oe_out <= 1'b0;
                state      <= S_TXACK;
              end else begin
                sh         <= {sh[6:0], 1'b0};
                sda_oe_out <= ~sh[6];
              end
            end
          end
          S_TXACK: begin
            if (scl_rise) begin
              ack_n <= sda_in;
            end else if (scl_fall) begin
              cnt <= 4'h0;
              if (!ack_n) begin
                sh         <= read_byte_in;
                sda_oe_out <= ~read_byte_in[7];
                state      <= S_TX;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          S_IDLE: begin
            sda_oe_out <= 1'b0;
          end
          default: begin
            state      <= S_IDLE;
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/mgmt_ctrl_sva.sv ====
// Port assertions for the management control block
`timescale 1ns/1ps
`default_nettype none
module mgmt_ctrl_sva #(
  parameter [25:0] INIT_CYCLES  = 26'h14,
  parameter [6:0]  PULSE_CYCLES = 7'h64
) (
  // Clock, reset, host reset pin and module event inputs
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic module_reset_n_in,
  input wire logic irq_event_in,
  // Outputs watched
  input wire logic sda_oe_out,
  input wire logic interrupt_out_n,
  input wire logic data_out_disable_out,
  input wire logic mgmt_ready_out
);
  // Saturating low time of the interrupt; wait since reset for ready
  logic [7:0]  low_cnt;
  logic [26:0] wait_cnt;
  always @(posedge ref_clk_in) begin
    if (!nrst_in || interrupt_out_n) low_cnt <= 8'h00;
    else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h01;
    if (!nrst_in || !module_reset_n_in) wait_cnt <= 27'h0;
    else if (!mgmt_ready_out) wait_cnt <= wait_cnt + 27'h1;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  int_low_a: assert property (
    irq_event_in && mgmt_ready_out && interrupt_out_n
    |-> ##[1:2] !interrupt_out_n) else $error("interrupt not raised");
  pulse_width_a: assert property (
    $rose(interrupt_out_n) && module_reset_n_in
    |-> low_cnt >= {1'b0, PULSE_CYCLES}) else $error("pulse too short");
  reset_quiet_a: assert property (
    !module_reset_n_in [*5] |-> interrupt_out_n && data_out_disable_out
    && !mgmt_ready_out) else $error("outputs live in reset");
  reset_no_ack_a: assert property (
    !module_reset_n_in [*5] |-> !sda_oe_out) else $error("ack in reset");
  ready_early_a: assert property (
    $rose(mgmt_ready_out) |-> wait_cnt + 27'h1 >= {1'b0, INIT_CYCLES})
    else $error("ready too early");
  ready_late_a: assert property (
    !mgmt_ready_out |-> wait_cnt <= {1'b0, INIT_CYCLES} + 27'h8)
    else $error("ready too late");
  bus_quiet_a: assert property (
    !mgmt_ready_out |-> !sda_oe_out) else $error("ack before ready");
  int_quiet_a: assert property (
    !mgmt_ready_out |-> interrupt_out_n) else $error("interrupt before ready");
  outputs_off_a: assert property (
    !mgmt_ready_out |-> data_out_disable_out) else $error("outputs on early");
  outputs_on_a: assert property (
    $rose(mgmt_ready_out) |-> ##[0:1] !data_out_disable_out)
    else $error("outputs not resumed");
  pulse_c: cover property ($rose(interrupt_out_n) && low_cnt > 8'h64);
  ack_c: cover property ($rose(sda_oe_out));
  ready_c: cover property ($rose(mgmt_ready_out));
endmodule
bind module_mgmt_control mgmt_ctrl_sva #(
  .INIT_CYCLES(INIT_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)
) u_mgmt_ctrl_sva (.ref_clk_in, .nrst_in, .module_reset_n_in,
  .irq_event_in, .sda_oe_out, .interrupt_out_n, .data_out_disable_out,
  .mgmt_ready_out);
`default_nettype wire

// ==== tb/host_mgmt_model.sv ====
// Host two-wire master model for the management port
`timescale 1ns/1ps
`default_nettype none
module host_mgmt_model (
  // Wire level of the data line
  input  wire logic sda_in,
  // Clock pushed, data pulled low only
  output var logic  scl_out,
  output var logic  sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // ----------------------------------------------------------------
  // Bit and frame tasks, 400 ns a bit
  // ----------------------------------------------------------------
  // Data moves only while the clock is low; clock idles high
  task automatic bitx(input logic b, output logic r);
    sda_low_out = ~b;
    #100 scl_out = 1'b1;
    #100 r = sda_in;
    #100 scl_out = 1'b0;
    #100;
  endtask
  task automatic start();
    sda_low_out = 1'b1;
    #200 scl_out = 1'b0;
    #100;
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    #100 scl_out = 1'b1;
    #100 sda_low_out = 1'b0;
    #200;
  endtask
  // Send d MSB first (ff to read), then mack as ninth bit
  task automatic xbyte(input logic [7:0] d, input logic mack,
                       output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(mack, r);
    ack = ~r;
  endtask
endmodule
`default_nettype wire

// ==== tb/module_mgmt_control_test.sv ====
// Self-checking bench for the management control block
`timescale 1ns/1ps
`default_nettype none
module module_mgmt_control_test;
  localparam [25:0] INIT  = 26'h14;
  localparam [6:0]  PULSE = 7'h64;
  logic       ref_clk_in        = 1'b0;
  logic       nrst_in           = 1'b0;
  logic       module_reset_n_in = 1'b1;
  logic [2:0] addr_sel_in       = 3'h5;
  logic       irq_event_in      = 1'b0;
  wire        scl, sda_low, sda_oe, sda_lvl, int_n, dis, ready;
  wire        sda_wire = ~(sda_low | sda_oe);
  int         failures = 0;
  int         samples_checked = 0;
  initial forever #25 ref_clk_in = ~ref_clk_in;
  module_mgmt_control #(.INIT_CYCLES(INIT), .PULSE_CYCLES(PULSE))
    u_module_mgmt_control (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .module_reset_n_in(module_reset_n_in), .addr_sel_in(addr_sel_in),
    .scl_in(scl), .sda_in(sda_wire), .irq_event_in(irq_event_in),
    .sda_out(sda_lvl), .sda_oe_out(sda_oe), .interrupt_out_n(int_n),
    .data_out_disable_out(dis), .mgmt_ready_out(ready));
  host_mgmt_model u_host_mgmt_model (.sda_in(sda_wire), .scl_out(scl),
    .sda_low_out(sda_low));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // Bounded wait on ready (s=1) or the interrupt (s=0)
  task automatic wt(input logic s, v, input int lim, output int n);
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while ((s ? ready : int_n) !== v && n < lim);
  endtask
  // Event lasts one cycle; only this task drives it
  task automatic fire();
    @(posedge ref_clk_in) irq_event_in <= 1'b1;
    @(posedge ref_clk_in) irq_event_in <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] s, output logic a,
                    output logic [7:0] q);
    logic x;
    q = 8'hff;
    u_host_mgmt_model.start();
    u_host_mgmt_model.xbyte({4'ha, s, 1'b1}, 1'b1, q, a);
    if (a) u_host_mgmt_model.xbyte(8'hff, 1'b1, q, x);
    u_host_mgmt_model.stop();
  endtask
  task automatic wr(input logic [7:0] d);
    logic       a0, a1;
    logic [7:0] q;
    u_host_mgmt_model.start();
    u_host_mgmt_model.xbyte({4'ha, addr_sel_in, 1'b0}, 1'b1, q, a0);
    u_host_mgmt_model.xbyte(d, 1'b1, q, a1);
    u_host_mgmt_model.stop();
    chk("write acks", {6'h00, a0, a1}, 8'h03);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_init();
    int n;
    wt(1'b1, 1'b1, 40, n);
    chk("init ready", {7'h00, ready}, 8'h01);
    $display("init test done");
  endtask
  task automatic t_addr();
    logic       a;
    logic [7:0] q;
    rd(3'h5, a, q);
    chk("ack at pins", {7'h00, a}, 8'h01);
    chk("idle flags", q, 8'h00);
    rd(3'h2, a, q);
    chk("foreign ack", {7'h00, a}, 8'h00);
    @(posedge ref_clk_in) addr_sel_in <= 3'h2;
    step(4);
    rd(3'h2, a, q);
    chk("new addr ack", {7'h00, a}, 8'h01);
    $display("address test done");
  endtask
  // Second event inside the pulse must not stretch it
  task automatic t_pulse();
    logic       a;
    logic [7:0] q;
    int         n;
    fire();
    wt(1'b0, 1'b0, 4, n);
    chk("int low", {7'h00, int_n}, 8'h00);
    step(10);
    fire();
    wt(1'b0, 1'b1, 200, n);
    chk("pulse len", n[7:0], {1'b0, PULSE} - 8'h0a);
    rd(3'h2, a, q);
    chk("pending", q, 8'h01);
    rd(3'h2, a, q);
    chk("cleared", q, 8'h00);
    $display("pulse test done");
  endtask
  task automatic t_static();
    logic       a;
    logic [7:0] q;
    int         n;
    wr(8'h01);
    fire();
    wt(1'b0, 1'b0, 4, n);
    step(300);
    chk("static held", {7'h00, int_n}, 8'h00);
    rd(3'h2, a, q);
    chk("static flags", q, 8'h03);
    wt(1'b0, 1'b1, 10000, n);
    chk("released", {7'h00, int_n}, 8'h01);
    wr(8'h00);
    rd(3'h2, a, q);
    chk("back to pulse", q, 8'h00);
    wr(8'h01);
    rd(3'h2, a, q);
    chk("static again", q, 8'h02);
    $display("static test done");
  endtask
  task automatic t_reset();
    logic       a;
    logic [7:0] q;
    int         n;
    @(posedge ref_clk_in) module_reset_n_in <= 1'b0;
    step(5);
    chk("reset state", {5'h00, dis, ready, int_n}, 8'h05);
    chk("reset sda", {6'h00, sda_lvl, sda_oe}, 8'h00);
    rd(3'h2, a, q);
    chk("reset ack", {7'h00, a}, 8'h00);
    @(posedge ref_clk_in) module_reset_n_in <= 1'b1;
    wt(1'b1, 1'b1, 40, n);
    chk("resumed", {6'h00, dis, ready}, 8'h01);
    rd(3'h2, a, q);
    chk("mode reset", q, 8'h00);
    fire();
    wt(1'b0, 1'b0, 4, n);
    wt(1'b0, 1'b1, 200, n);
    // The registered pin stays low one cycle past the timer
    chk("pulse again", n[7:0], {1'b0, PULSE} + 8'h01);
    $display("reset test done");
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    step(10);
    @(posedge ref_clk_in) nrst_in <= 1'b1;
    t_init();
    t_addr();
    t_pulse();
    t_static();
    t_reset();
    results();
  end
  initial begin
    #1000000;
    failures++;
    results();
  end
endmodule
`default_nettype wire
